// *** verilog/ecd_pkg.sv ***
`default_nettype none
package ecd_pkg;
  // parameter group numbers of the three received groups
  localparam logic [15:0] PGN_ENGINE_CONTROL = 16'hFF1C; // 65308
  localparam logic [15:0] PGN_ENGINE_STOP    = 16'hFF1D; // 65309
  localparam logic [15:0] PGN_SPEED_SELECT   = 16'hFF1E; // 65310
  localparam logic [3:0]  FRAME_DLC          = 4'h8;
  localparam logic [7:0]  FILL_BYTE          = 8'hFF;

  // field positions, bit 1 of byte 1 is frame_data[0]
  localparam int LIMIT_ONE_POS     = 0;
  localparam int LIMIT_TWO_POS     = 1;
  localparam int DROOP_POS         = 2;
  localparam int REV_DROOP_POS     = 3;
  localparam int STARTER_POS       = 4;
  localparam int HI_IDLE_POS       = 5;
  localparam int HI_IDLE_SPD_POS   = 6;
  localparam int STOP_POS          = 0;
  localparam int SEL_POS           = 0;
  localparam int SPEED_UP_POS      = 8;

  localparam logic [1:0]  STOP_NONE    = 2'h0;
  localparam logic [1:0]  STOP_REQUEST = 2'h1;
  // largest legal setpoint, 8031.875 rpm at 0.125 rpm per bit
  localparam logic [15:0] SPEED_UP_MAX = 16'hFAFF;

  // reset values of the held fields
  localparam logic [6:0]  ENGINE_CTRL_RESET = 7'h10; // starter prevention on
  localparam logic [4:0]  SPEED_SEL_RESET   = 5'h00;
  localparam logic [15:0] SPEED_UP_RESET    = 16'h0000;

  // control index, order of the cfg_map slots
  localparam int C_LIMIT_ONE   = 0;
  localparam int C_LIMIT_TWO   = 1;
  localparam int C_DROOP       = 2;
  localparam int C_REV_DROOP   = 3;
  localparam int C_STARTER     = 4;
  localparam int C_HI_IDLE     = 5;
  localparam int C_HI_IDLE_SPD = 6;
  localparam int C_SPEED_ONE   = 7;
  localparam int C_SPEED_TWO   = 8;
  localparam int C_IMPL_UP     = 9;
  localparam int C_IMPL_DOWN   = 10;
  localparam int C_SEL_ENABLE  = 11;
  localparam int C_STOP        = 12;
  localparam int NUM_CTRL      = 13;

  // app input numbers 1..7 (app_input_one .. app_input_seven)
  typedef logic [2:0] ecd_app_sel_t;
  // default mapping, slot k at bits 3k+2:3k
  localparam logic [38:0] DEFAULT_MAP = {
    3'h7, 3'h6, 3'h6, 3'h5, 3'h4, 3'h3,
    3'h7, 3'h5, 3'h1, 3'h5, 3'h1, 3'h2, 3'h7};
endpackage
`default_nettype wire

// *** verilog/ecd_can_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface ecd_can_if;
  logic        frame_valid;
  logic [15:0] frame_pgn;
  logic [3:0]  frame_dlc;
  logic [63:0] frame_data;

  modport controller (output frame_valid, output frame_pgn,
                      output frame_dlc, output frame_data);
  modport engine     (input frame_valid, input frame_pgn,
                      input frame_dlc, input frame_data);
endinterface
`default_nettype wire

// *** verilog/ecd_engine_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (RQ1) byte1 bits 1,2 switch speed limits
// (RQ2) outputs off after reset until frame
// (RQ3) bus error keeps last received values
// (RQ4) byte1 bit3 one selects droop governing
// (RQ5) byte1 bit4 one selects reverse droop
// (RQ6) byte1 bit5 one prevents starting
// (RQ7) starter prevents after reset, permits on error
// (RQ8) bits 6,7 switch high idle limit
// (RQ9) stop code 00 none, 01 stop, others ignored
// (RQ10) five bit speed selection field layout
// (RQ11) selection drives constant speed and deceleration
// (RQ12) 16-bit speed-up setpoint from byte 2
// (RQ13) each bit gated by configured app input
// (RQ14) update only on complete matching frame
module ecd_engine_decoder (
  input  wire logic        clk,
  input  wire logic        rst_n,
  ecd_can_if.engine        can,
  input  wire logic        bus_error,
  input  wire logic [7:1]  app_func_enable,
  input  wire logic [38:0] cfg_map,
  output logic             speed_limit_one,
  output logic             speed_limit_two,
  output logic             droop_mode,
  output logic             reverse_droop_mode,
  output logic             starter_prevent,
  output logic             hi_idle_limit,
  output logic             hi_idle_limit_speed,
  output logic             engine_stop_request,
  output logic             speed_one,
  output logic             speed_two,
  output logic             implement_up,
  output logic             implement_down,
  output logic             speed_select_enable,
  output logic             constant_speed,
  output logic             constant_decel,
  output logic [15:0]      speed_up_setpoint
);
  logic [6:0]  engine_ctrl;
  logic        stop_held;
  logic [4:0]  speed_sel;
  logic [15:0] speed_up;
  localparam int NUM_W = ecd_pkg::NUM_CTRL;

  logic        frame_ok;
  logic [NUM_W-1:0] gated;

  // a control acts only while the app input it is mapped to is enabled
  function automatic logic app_gate(input logic bit_in,
                                    input logic [38:0] map,
                                    input logic [7:1] en,
                                    input int slot);
    ecd_pkg::ecd_app_sel_t sel;
    sel = map[3*slot +: 3];
    if (sel == 3'h0) begin
      app_gate = 1'b0;
    end else begin
      app_gate = bit_in & en[sel];
    end
  endfunction

  // errored bus frames are not trusted, so no held field updates meanwhile
  assign frame_ok = can.frame_valid && !bus_error &&
                    can.frame_dlc == ecd_pkg::FRAME_DLC; // RQ14 RQ3

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_ctrl <= ecd_pkg::ENGINE_CTRL_RESET; // RQ2 RQ7
    end else if (frame_ok &&
                 can.frame_pgn == ecd_pkg::PGN_ENGINE_CONTROL) begin
      engine_ctrl <= can.frame_data[6:0]; // RQ1 RQ4 RQ5 RQ6 RQ8 RQ14
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_held <= 1'b0;
    end else if (frame_ok &&
                 can.frame_pgn == ecd_pkg::PGN_ENGINE_STOP) begin
      unique case (can.frame_data[ecd_pkg::STOP_POS +: 2])
        ecd_pkg::STOP_NONE:    stop_held <= 1'b0; // RQ9
        ecd_pkg::STOP_REQUEST: stop_held <= 1'b1; // RQ9
        default:               stop_held <= stop_held; // RQ9
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_sel <= ecd_pkg::SPEED_SEL_RESET; // RQ2
      speed_up  <= ecd_pkg::SPEED_UP_RESET; // RQ12
    end else if (frame_ok &&
                 can.frame_pgn == ecd_pkg::PGN_SPEED_SELECT) begin
      speed_sel <= can.frame_data[ecd_pkg::SEL_POS +: 5]; // RQ10
      // error and not-available codes lie above the maximum
      if (can.frame_data[ecd_pkg::SPEED_UP_POS +: 16] <=
          ecd_pkg::SPEED_UP_MAX) begin
        speed_up <= can.frame_data[ecd_pkg::SPEED_UP_POS +: 16]; // RQ12
      end
    end
  end

  always_comb begin
    gated = '0;
    gated[ecd_pkg::C_LIMIT_ONE] = app_gate(
      engine_ctrl[ecd_pkg::LIMIT_ONE_POS], cfg_map, app_func_enable,
      ecd_pkg::C_LIMIT_ONE); // RQ13
    gated[ecd_pkg::C_LIMIT_TWO] = app_gate(
      engine_ctrl[ecd_pkg::LIMIT_TWO_POS], cfg_map, app_func_enable,
      ecd_pkg::C_LIMIT_TWO);
    gated[ecd_pkg::C_DROOP] = app_gate(
      engine_ctrl[ecd_pkg::DROOP_POS], cfg_map, app_func_enable,
      ecd_pkg::C_DROOP);
    gated[ecd_pkg::C_REV_DROOP] = app_gate(
      engine_ctrl[ecd_pkg::REV_DROOP_POS], cfg_map, app_func_enable,
      ecd_pkg::C_REV_DROOP);
    gated[ecd_pkg::C_STARTER] = app_gate(
      engine_ctrl[ecd_pkg::STARTER_POS], cfg_map, app_func_enable,
      ecd_pkg::C_STARTER);
    gated[ecd_pkg::C_HI_IDLE] = app_gate(
      engine_ctrl[ecd_pkg::HI_IDLE_POS], cfg_map, app_func_enable,
      ecd_pkg::C_HI_IDLE);
    gated[ecd_pkg::C_HI_IDLE_SPD] = app_gate(
      engine_ctrl[ecd_pkg::HI_IDLE_SPD_POS], cfg_map, app_func_enable,
      ecd_pkg::C_HI_IDLE_SPD);
    for (int i = 0; i < 5; i++) begin
      gated[ecd_pkg::C_SPEED_ONE + i] = app_gate(speed_sel[i], cfg_map,
        app_func_enable, ecd_pkg::C_SPEED_ONE + i); // RQ13
    end
    gated[ecd_pkg::C_STOP] = app_gate(stop_held, cfg_map,
      app_func_enable, ecd_pkg::C_STOP);
  end

  // outputs registered one cycle after the held state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_limit_one <= 1'b0; // RQ2
      speed_limit_two <= 1'b0; // RQ2
    end else begin
      speed_limit_one <= gated[ecd_pkg::C_LIMIT_ONE]; // RQ1
      speed_limit_two <= gated[ecd_pkg::C_LIMIT_TWO]; // RQ1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      droop_mode         <= 1'b0; // RQ2
      reverse_droop_mode <= 1'b0; // RQ2
    end else begin
      droop_mode         <= gated[ecd_pkg::C_DROOP]; // RQ4
      reverse_droop_mode <= gated[ecd_pkg::C_REV_DROOP]; // RQ5
    end
  end

  // on bus error the engine must stay startable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      starter_prevent <= 1'b1; // RQ7
    end else begin
      starter_prevent <= gated[ecd_pkg::C_STARTER] && !bus_error; // RQ6 RQ7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_idle_limit       <= 1'b0; // RQ2
      hi_idle_limit_speed <= 1'b0; // RQ2
    end else begin
      hi_idle_limit       <= gated[ecd_pkg::C_HI_IDLE]; // RQ8
      hi_idle_limit_speed <= gated[ecd_pkg::C_HI_IDLE_SPD]; // RQ8
    end
  end

  // the stop request has no bus-error fallback, it keeps its state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_stop_request <= 1'b0;
    end else begin
      engine_stop_request <= gated[ecd_pkg::C_STOP]; // RQ9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_one           <= 1'b0; // RQ2
      speed_two           <= 1'b0; // RQ2
      implement_up        <= 1'b0; // RQ2
      implement_down      <= 1'b0; // RQ2
      speed_select_enable <= 1'b0; // RQ2
    end else begin
      speed_one           <= gated[ecd_pkg::C_SPEED_ONE]; // RQ10
      speed_two           <= gated[ecd_pkg::C_SPEED_TWO]; // RQ10
      implement_up        <= gated[ecd_pkg::C_IMPL_UP]; // RQ10
      implement_down      <= gated[ecd_pkg::C_IMPL_DOWN]; // RQ10
      speed_select_enable <= gated[ecd_pkg::C_SEL_ENABLE]; // RQ10
    end
  end

  // both modes follow the gated bits, so a disabled input drops them too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      constant_speed <= 1'b0; // RQ2
      constant_decel <= 1'b0; // RQ2
    end else begin
      constant_speed <= gated[ecd_pkg::C_SEL_ENABLE] &&
        (gated[ecd_pkg::C_SPEED_ONE] ||
         gated[ecd_pkg::C_SPEED_TWO]); // RQ11
      constant_decel <= gated[ecd_pkg::C_SEL_ENABLE] &&
        (gated[ecd_pkg::C_IMPL_UP] ||
         gated[ecd_pkg::C_IMPL_DOWN]); // RQ11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_up_setpoint <= ecd_pkg::SPEED_UP_RESET; // RQ2
    end else begin
      speed_up_setpoint <= speed_up; // RQ12
    end
  end
endmodule
`default_nettype wire

// *** verilog/ecd_machine_sender.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecd_machine_sender (
  input  wire logic        clk,
  input  wire logic        rst_n,
  ecd_can_if.controller    can,
  input  wire logic        send_control,
  input  wire logic [6:0]  control_bits,
  output logic             control_ready,
  input  wire logic        send_stop,
  input  wire logic [1:0]  stop_code,
  output logic             stop_ready,
  input  wire logic        send_select,
  input  wire logic [4:0]  select_bits,
  input  wire logic [15:0] speed_up,
  output logic             select_ready
);
  // fixed priority, lower groups wait while a higher one is offered
  assign control_ready = 1'b1;
  assign stop_ready    = !send_control;
  assign select_ready  = !send_control && !send_stop;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      can.frame_valid <= 1'b0;
      can.frame_pgn   <= 16'h0000;
      can.frame_dlc   <= 4'h0;
      can.frame_data  <= 64'h0000000000000000;
    end else begin
      can.frame_valid <= send_control || send_stop || send_select;
      can.frame_dlc   <= ecd_pkg::FRAME_DLC;
      if (send_control) begin
        can.frame_pgn  <= ecd_pkg::PGN_ENGINE_CONTROL;
        can.frame_data <= {{7{ecd_pkg::FILL_BYTE}}, 1'b1,
                           control_bits}; // RQ1 RQ4 RQ5 RQ6 RQ8
      end else if (send_stop) begin
        can.frame_pgn  <= ecd_pkg::PGN_ENGINE_STOP;
        can.frame_data <= {{7{ecd_pkg::FILL_BYTE}}, 6'h3F,
                           stop_code}; // RQ9
      end else if (send_select) begin
        can.frame_pgn  <= ecd_pkg::PGN_SPEED_SELECT;
        can.frame_data <= {{5{ecd_pkg::FILL_BYTE}}, speed_up, 3'h7,
                           select_bits}; // RQ10 RQ12
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/ecd_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecd_link_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        frame_valid,
  input wire logic [15:0] frame_pgn,
  input wire logic [3:0]  frame_dlc,
  input wire logic [63:0] frame_data,
  input wire logic        bus_error,
  input wire logic [7:1]  app_func_enable,
  input wire logic [38:0] cfg_map,
  input wire logic        speed_limit_one,
  input wire logic        droop_mode,
  input wire logic        starter_prevent,
  input wire logic        engine_stop_request,
  input wire logic        speed_select_enable,
  input wire logic        speed_one,
  input wire logic        speed_two,
  input wire logic        implement_up,
  input wire logic        implement_down,
  input wire logic        constant_speed,
  input wire logic        constant_decel,
  input wire logic [15:0] speed_up_setpoint
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic gate_ok;
  // field checks only hold with every input enabled on the usual mapping
  assign gate_ok = (&app_func_enable) && (cfg_map == ecd_pkg::DEFAULT_MAP);
  sequence take_s(logic [15:0] pgn);
    frame_valid && frame_pgn == pgn && frame_dlc == ecd_pkg::FRAME_DLC
      && !bus_error && gate_ok;
  endsequence
  limit_one_a: assert property (take_s(ecd_pkg::PGN_ENGINE_CONTROL) |->
    ##2 speed_limit_one == $past(frame_data[0], 2)) else $error("limit one");
  droop_mode_a: assert property (take_s(ecd_pkg::PGN_ENGINE_CONTROL) |->
    ##2 droop_mode == $past(frame_data[2], 2)) else $error("droop mode");
  starter_bit_a: assert property (take_s(ecd_pkg::PGN_ENGINE_CONTROL)
    |-> ##2 starter_prevent == $past(frame_data[4], 2)) else $error("starter");
  stop_code_a: assert property (take_s(ecd_pkg::PGN_ENGINE_STOP)
    ##0 !frame_data[1] |-> ##2 engine_stop_request == $past(frame_data[0], 2))
    else $error("stop code");
  stop_ignore_a: assert property (take_s(ecd_pkg::PGN_ENGINE_STOP)
    ##0 frame_data[1] |-> ##2 $stable(engine_stop_request))
    else $error("stop code not ignored");
  setpoint_load_a: assert property (take_s(ecd_pkg::PGN_SPEED_SELECT)
    ##0 frame_data[23:8] <= ecd_pkg::SPEED_UP_MAX |->
    ##2 speed_up_setpoint == $past(frame_data[23:8], 2))
    else $error("setpoint");
  error_permit_a: assert property (bus_error [*3] |-> !starter_prevent)
    else $error("starter not released on bus error");
  error_hold_a: assert property (bus_error [*3] |-> $stable(droop_mode)
    && $stable(speed_limit_one) && $stable(speed_up_setpoint))
    else $error("output moved during bus error");
  reset_state_a: assert property ($rose(rst_n) |-> starter_prevent
    && !speed_limit_one && !droop_mode && !speed_select_enable
    && speed_up_setpoint == 16'h0000) else $error("reset state");
  frame_len_a: assert property (frame_valid |->
    frame_dlc == ecd_pkg::FRAME_DLC
    && frame_data[63:24] == {5{ecd_pkg::FILL_BYTE}})
    else $error("frame length");
  const_speed_a: assert property (constant_speed ==
    (speed_select_enable && (speed_one || speed_two)))
    else $error("const speed");
  const_decel_a: assert property (constant_decel ==
    (speed_select_enable && (implement_up || implement_down)))
    else $error("const decel");
endmodule
`default_nettype wire

// *** verif/engine_can_command_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module engine_can_command_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        bus_error = 1'b0;
  logic [7:1]  app_func_enable = 7'h7F;
  logic [38:0] cfg_map = ecd_pkg::DEFAULT_MAP;
  logic [2:0]  req = 3'h0;
  logic [6:0]  control_bits = 7'h00;
  logic [1:0]  stop_code = 2'h0;
  logic [4:0]  select_bits = 5'h00;
  logic [15:0] speed_up = 16'h0000;
  logic [6:0]  ctl;
  logic [4:0]  sel;
  logic        stop, cs, cd;
  logic [15:0] sp;
  int          checked = 0;
  int          n_errors = 0;
  always #50 clk = ~clk;
  ecd_can_if if_can ();
  ecd_machine_sender u_ecd_machine_sender (
    .clk(clk), .rst_n(rst_n), .can(if_can.controller),
    .send_control(req[0]), .control_bits(control_bits), .control_ready(),
    .send_stop(req[1]), .stop_code(stop_code), .stop_ready(),
    .send_select(req[2]), .select_bits(select_bits), .speed_up(speed_up),
    .select_ready());
  ecd_engine_decoder u_ecd_engine_decoder (
    .clk(clk), .rst_n(rst_n), .can(if_can.engine), .bus_error(bus_error),
    .app_func_enable(app_func_enable), .cfg_map(cfg_map),
    .speed_limit_one(ctl[0]), .speed_limit_two(ctl[1]), .droop_mode(ctl[2]),
    .reverse_droop_mode(ctl[3]), .starter_prevent(ctl[4]),
    .hi_idle_limit(ctl[5]), .hi_idle_limit_speed(ctl[6]),
    .engine_stop_request(stop), .speed_one(sel[0]), .speed_two(sel[1]),
    .implement_up(sel[2]), .implement_down(sel[3]),
    .speed_select_enable(sel[4]), .constant_speed(cs), .constant_decel(cd),
    .speed_up_setpoint(sp));
  ecd_link_checker u_ecd_link_checker (
    .clk(clk), .rst_n(rst_n), .frame_valid(if_can.frame_valid),
    .frame_pgn(if_can.frame_pgn), .frame_dlc(if_can.frame_dlc),
    .frame_data(if_can.frame_data), .bus_error(bus_error),
    .app_func_enable(app_func_enable), .cfg_map(cfg_map),
    .speed_limit_one(ctl[0]), .droop_mode(ctl[2]), .starter_prevent(ctl[4]),
    .engine_stop_request(stop), .speed_select_enable(sel[4]),
    .speed_one(sel[0]), .speed_two(sel[1]), .implement_up(sel[2]),
    .implement_down(sel[3]), .constant_speed(cs), .constant_decel(cd),
    .speed_up_setpoint(sp));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one request per call, so the sender's priority never refuses it
  task automatic send(input logic [2:0] k, input logic [20:0] v);
    control_bits = v[6:0];
    stop_code = v[1:0];
    {speed_up, select_bits} = v;
    req = k;
    @(negedge clk);
    req = 3'h0;
    repeat (5) @(negedge clk);
  endtask
  task automatic t_control();
    for (int i = 0; i < 7; i++) begin
      send(3'h1, 21'(7'h01 << i));
      check({9'h0, ctl}, 16'(7'h01 << i));
    end
  endtask
  task automatic t_stop();
    send(3'h2, 21'h1);
    check({15'h0, stop}, 16'h0001);
    send(3'h2, 21'h2);
    check({15'h0, stop}, 16'h0001);
    send(3'h2, 21'h0);
    check({15'h0, stop}, 16'h0000);
    send(3'h2, 21'h3);
    check({15'h0, stop}, 16'h0000);
  endtask
  task automatic t_select();
    for (int i = 0; i < 5; i++) begin
      send(3'h4, {16'h0100 << i, 5'h01 << i});
      check({11'h0, sel}, 16'h0001 << i);
      check(sp, 16'h0100 << i);
      check({14'h0, cd, cs}, 16'h0000);
    end
    send(3'h4, {ecd_pkg::SPEED_UP_MAX, 5'h12});
    check(sp, 16'hFAFF);
    check({14'h0, cd, cs}, 16'h0001);
    // setpoint above the limit is dropped, byte one still lands
    send(3'h4, {16'hFB00, 5'h18});
    check(sp, 16'hFAFF);
    check({14'h0, cd, cs}, 16'h0002);
  endtask
  task automatic t_error();
    send(3'h1, 21'h7F);
    bus_error = 1'b1;
    repeat (4) @(negedge clk);
    check({9'h0, ctl}, 16'h006F);
    send(3'h1, 21'h00);
    send(3'h4, {16'h0010, 5'h00});
    check({9'h0, ctl}, 16'h006F);
    check({11'h0, sel}, 16'h0018);
    check(sp, 16'hFAFF);
    bus_error = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_gate();
    send(3'h1, 21'h41);
    app_func_enable[7] = 1'b0;
    repeat (3) @(negedge clk);
    check({9'h0, ctl}, 16'h0000);
    app_func_enable[7] = 1'b1;
    cfg_map[2:0] = 3'h0;
    repeat (3) @(negedge clk);
    check({9'h0, ctl}, 16'h0040);
    cfg_map = ecd_pkg::DEFAULT_MAP;
    repeat (3) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // also used at the end of the run, when every held field but stop_held carries a non-reset value
  task automatic t_reset();
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({9'h0, ctl}, 16'h0010);
    check({8'h0, stop, cd, cs, sel}, 16'h0000);
    check(sp, 16'h0000);
  endtask
  initial begin
    t_reset();
    t_control();
    t_stop();
    t_select();
    t_error();
    t_gate();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
